// File: protection_params.svh
// Purpose: Named constants for the protection reaction sequencer
// Assumes: 20 MHz clock
// Notes:   Times in their own unit, cycle counts derived from them
`ifndef PROTECTION_PARAMS_SVH
`define PROTECTION_PARAMS_SVH
`define CLK_PERIOD_NS        50
`define FIXED_HALF_PERIOD_NS 9823000
`define MS_NS                1000000
`define US_NS                1000
`define US_CYC               (`US_NS / `CLK_PERIOD_NS)
`define OC_BLANK_MIN_NS      100
`define OC_BLANK_MIN_CYC     ((`OC_BLANK_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PERIOD_W             18
`define GATE_OFF_DIV         512
`define SUPPLY_SAMPLES       63
`define RESTART_MIN_MS       12'h190
`define RESTART_MAX_MS       12'hFA0
`define FAST_RESTART_MS      12'h190
`define OUV_BLANK_MIN_MS     10'h005
`define OUV_BLANK_MAX_MS     10'h3E8
`define SOVP_MIN_DV          8'hE6
`define SOVP_MAX_DV          8'hF9
`define CODE_NONE            16'h0000
`define CODE_INPUT_UV        16'h0040
`define CODE_MISC            16'h0020
`define CODE_INPUT_OV        16'h0080
`define CODE_OUTPUT_OV       16'h0100
`define CODE_OUTPUT_UV       16'h0200
`define CODE_OVERCURRENT     16'h0400
`define CODE_SUPPLY_UV       16'h0800
`define CODE_SUPPLY_OV       16'h1000
`define CODE_OVERTEMP        16'h2000
`define CODE_FAST_WD         16'h4000
`define CODE_STOP            16'h8000
`endif

// File: protection_pkg.sv
// Purpose: Types of the protection reaction sequencer
// Assumes: Constants come from protection_params.svh
// Notes:   Types only
package protection_pkg;
   typedef enum logic [3:0] {st_recharge, st_prestart, st_startup, st_regulated,
                             st_latched, st_stopped, st_wait, st_discharge} seq_state_t;
   typedef enum logic [1:0] {react_auto, react_fast, react_latch, react_stop} reaction_t;
   typedef struct packed {
      logic input_uv;
      logic input_ov;
      logic output_ov;
      logic output_uv;
      logic overcurrent;
      logic supply_uv;
      logic overtemp;
      logic fast_watchdog;
      logic stop_fault;
      logic misc_fault;
   } faults_t;
   typedef struct packed {
      logic [11:0] restart_delay_ms;
      logic [9:0]  discharge_pulse_width;
      logic [9:0]  output_undervoltage_blanking;
      logic [7:0]  overcurrent_blanking;
      logic [7:0]  supply_ovp_threshold;
      logic        output_overvoltage_reaction_select;
      logic        supply_overvoltage_reaction_select;
      logic        input_overvoltage_enable;
      logic        input_undervoltage_enable;
      logic        debug_halt;
   } config_t;
endpackage : protection_pkg

// File: period_divider.sv
// Purpose: Spreads DIV evenly spaced ticks over one half-sine period
// Assumes: i_period in clock cycles, at least DIV
// Notes:   Fractional accumulator, so spacing averages exactly period/DIV
`timescale 1ns/1ps
`include "protection_params.svh"
module period_divider #(
   parameter int DIV = 512
) (
   input  wire logic                 i_mclk,
   input  wire logic                 i_resetn,
   input  wire logic [`PERIOD_W-1:0] i_period,
   output logic                      o_tick
);
   localparam logic [`PERIOD_W:0] STEP = (`PERIOD_W + 1)'(DIV);
   logic [`PERIOD_W:0] acc_reg;
   logic [`PERIOD_W:0] acc_next;
   logic [`PERIOD_W:0] sum;
   logic               tick_next;

   always_comb begin
      sum = acc_reg + STEP;
      if (sum >= {1'b0, i_period}) begin
         acc_next  = sum - {1'b0, i_period};
         tick_next = 1'b1;
      end else begin
         acc_next  = sum;
         tick_next = 1'b0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         acc_reg <= '0;
         o_tick  <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         o_tick  <= tick_next;
      end
   end

   // Period of at least twice DIV cycles never gives two ticks in a row
   a_tick_spacing: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (o_tick && {1'b0, i_period} >= (STEP << 1) && $stable(i_period)) |=> !o_tick)
      else $error("divider ticks too close");
endmodule : period_divider

// File: protection_reaction_sequencer.sv
// Purpose: Reaction sequence after a protection trips in a flyback controller
// Assumes: Trip conditions and supply comparators arrive synchronous to i_mclk
// Notes:   Status code survives auto-restarts; a hardware restart clears it
`timescale 1ns/1ps
`include "protection_params.svh"
module protection_reaction_sequencer #(
   parameter int FIXED_HALF_PERIOD_CYC = `FIXED_HALF_PERIOD_NS / `CLK_PERIOD_NS,
   parameter int MS_TICK_CYCLES        = `MS_NS / `CLK_PERIOD_NS
) (
   input  wire logic                    i_mclk,
   input  wire logic                    i_resetn,
   input  wire logic                    i_line_sync_valid,
   input  wire logic [`PERIOD_W-1:0]    i_line_period,
   input  wire protection_pkg::faults_t i_faults,
   input  wire protection_pkg::config_t i_config,
   input  wire logic [7:0]              i_supply_sample,
   input  wire logic                    i_supply_below_off,
   input  wire logic                    i_supply_below_lower,
   input  wire logic                    i_supply_above_upper,
   input  wire logic                    i_prestart_done,
   input  wire logic                    i_input_above_start_max,
   input  wire logic                    i_input_below_start_min,
   input  wire logic                    i_startup_done,
   output logic                         o_gate_enable,
   output logic                         o_discharge_pulse,
   output logic                         o_hv_startup_enable,
   output logic                         o_hw_restart,
   output logic [15:0]                  o_status_code,
   output protection_pkg::seq_state_t   o_state
);
   localparam logic [`PERIOD_W-1:0] FIXED_PERIOD = `PERIOD_W'(FIXED_HALF_PERIOD_CYC);
   localparam logic [15:0]          MS_LAST      = 16'(MS_TICK_CYCLES - 1);
   localparam logic [7:0]           OC_MIN       = 8'(`OC_BLANK_MIN_CYC);
   localparam logic [15:0]          US_CYC       = 16'(`US_CYC);

   protection_pkg::seq_state_t state_reg;
   protection_pkg::seq_state_t state_next;
   protection_pkg::reaction_t  react;
   logic [`PERIOD_W-1:0] half_period;
   logic                 gate_tick;
   logic                 sample_tick;
   logic [15:0]          ms_cnt_reg;
   logic                 ms_tick;
   logic [11:0]          restart_ms;
   logic [9:0]           ouv_blank;
   logic [7:0]           oc_blank;
   logic [7:0]           sovp_thr;
   logic [7:0]           oc_cnt_reg;
   logic                 oc_trip;
   logic [9:0]           ouv_cnt_reg;
   logic                 ouv_trip;
   logic                 sovp_reg;
   logic                 in_ov;
   logic                 in_uv;
   logic                 active;
   logic                 trip;
   logic                 any_fault;
   logic [15:0]          code;
   logic [11:0]          wait_cnt_reg;
   logic [15:0]          dis_cnt_reg;
   logic                 hv_hold;

   assign o_state = state_reg;

   // Measured line period only once synchronisation holds and it is sane
   always_comb begin
      if (i_line_sync_valid && i_line_period != '0) begin
         half_period = i_line_period;
      end else begin
         half_period = FIXED_PERIOD;
      end
   end

   period_divider #(.DIV(`GATE_OFF_DIV)) u_gate_div (
      .i_mclk   (i_mclk),
      .i_resetn (i_resetn),
      .i_period (half_period),
      .o_tick   (gate_tick)
   );

   period_divider #(.DIV(`SUPPLY_SAMPLES)) u_sample_div (
      .i_mclk   (i_mclk),
      .i_resetn (i_resetn),
      .i_period (half_period),
      .o_tick   (sample_tick)
   );

   always_ff @(posedge i_mclk) begin
      if (!i_resetn || ms_cnt_reg == MS_LAST) begin
         ms_cnt_reg <= '0;
      end else begin
         ms_cnt_reg <= ms_cnt_reg + 16'h0001;
      end
   end
   assign ms_tick = (ms_cnt_reg == MS_LAST);

   // Out-of-range settings are clamped rather than refused
   always_comb begin
      restart_ms = i_config.restart_delay_ms;
      if (restart_ms < `RESTART_MIN_MS) restart_ms = `RESTART_MIN_MS;
      if (restart_ms > `RESTART_MAX_MS) restart_ms = `RESTART_MAX_MS;
      ouv_blank = i_config.output_undervoltage_blanking;
      if (ouv_blank < `OUV_BLANK_MIN_MS) ouv_blank = `OUV_BLANK_MIN_MS;
      if (ouv_blank > `OUV_BLANK_MAX_MS) ouv_blank = `OUV_BLANK_MAX_MS;
      oc_blank = i_config.overcurrent_blanking;
      if (oc_blank < OC_MIN) oc_blank = OC_MIN;
      sovp_thr = i_config.supply_ovp_threshold;
      if (sovp_thr < `SOVP_MIN_DV) sovp_thr = `SOVP_MIN_DV;
      if (sovp_thr > `SOVP_MAX_DV) sovp_thr = `SOVP_MAX_DV;
   end

   assign active = (state_reg == protection_pkg::st_prestart) ||
                   (state_reg == protection_pkg::st_startup) ||
                   (state_reg == protection_pkg::st_regulated);

   always_ff @(posedge i_mclk) begin
      if (!i_resetn || !active || !i_faults.overcurrent) begin
         oc_cnt_reg <= '0;
      end else if (!oc_trip) begin
         oc_cnt_reg <= oc_cnt_reg + 8'h01;
      end
   end
   assign oc_trip = (oc_cnt_reg >= oc_blank);

   always_ff @(posedge i_mclk) begin
      if (!i_resetn || state_reg != protection_pkg::st_regulated || !i_faults.output_uv) begin
         ouv_cnt_reg <= '0;
      end else if (ms_tick && !ouv_trip) begin
         ouv_cnt_reg <= ouv_cnt_reg + 10'h001;
      end
   end
   assign ouv_trip = (ouv_cnt_reg >= ouv_blank);

   // Stale samples are dropped outside the running states
   always_ff @(posedge i_mclk) begin
      if (!i_resetn || !active) begin
         sovp_reg <= 1'b0;
      end else if (sample_tick) begin
         sovp_reg <= (i_supply_sample > sovp_thr);
      end
   end

   assign in_ov = i_config.input_overvoltage_enable && (i_faults.input_ov ||
                  (state_reg == protection_pkg::st_prestart && i_prestart_done && i_input_above_start_max));
   assign in_uv = i_config.input_undervoltage_enable && (i_faults.input_uv ||
                  (state_reg == protection_pkg::st_prestart && i_prestart_done && i_input_below_start_min));

   // Fixed priority picks one winner when several trip together
   always_comb begin
      any_fault = 1'b1;
      code      = `CODE_NONE;
      react     = protection_pkg::react_auto;
      if (i_faults.stop_fault) begin
         code  = `CODE_STOP;
         react = protection_pkg::react_stop;
      end else if (sovp_reg) begin
         code  = `CODE_SUPPLY_OV;
         react = i_config.supply_overvoltage_reaction_select ?
                 protection_pkg::react_latch : protection_pkg::react_auto;
      end else if (i_faults.output_ov) begin
         code  = `CODE_OUTPUT_OV;
         react = i_config.output_overvoltage_reaction_select ?
                 protection_pkg::react_latch : protection_pkg::react_auto;
      end else if (oc_trip) begin
         code = `CODE_OVERCURRENT;
      end else if (i_faults.overtemp) begin
         code = `CODE_OVERTEMP;
      end else if (in_ov) begin
         code = `CODE_INPUT_OV;
      end else if (in_uv) begin
         code = `CODE_INPUT_UV;
      end else if (ouv_trip) begin
         code = `CODE_OUTPUT_UV;
      end else if (i_faults.supply_uv) begin
         code = `CODE_SUPPLY_UV;
      end else if (i_faults.fast_watchdog) begin
         code  = `CODE_FAST_WD;
         react = protection_pkg::react_fast;
      end else if (i_faults.misc_fault) begin
         code = `CODE_MISC;
      end else begin
         any_fault = 1'b0;
      end
      if (i_config.debug_halt) begin
         react = protection_pkg::react_stop;
      end
   end

   assign trip = active && any_fault;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         protection_pkg::st_recharge: begin
            if (!i_supply_below_lower) state_next = protection_pkg::st_prestart;
         end
         protection_pkg::st_prestart: begin
            if (i_prestart_done) state_next = protection_pkg::st_startup;
         end
         protection_pkg::st_startup: begin
            if (i_startup_done) state_next = protection_pkg::st_regulated;
         end
         protection_pkg::st_regulated: begin
            state_next = protection_pkg::st_regulated;
         end
         protection_pkg::st_latched, protection_pkg::st_stopped: begin
            if (i_supply_below_off) state_next = protection_pkg::st_recharge;
         end
         protection_pkg::st_wait: begin
            if (wait_cnt_reg == '0) state_next = protection_pkg::st_discharge;
         end
         protection_pkg::st_discharge: begin
            if (dis_cnt_reg <= 16'h0001) state_next = protection_pkg::st_recharge;
         end
         default: state_next = protection_pkg::st_recharge;
      endcase
      if (trip) begin
         unique case (react)
            protection_pkg::react_latch: state_next = protection_pkg::st_latched;
            protection_pkg::react_stop:  state_next = protection_pkg::st_stopped;
            protection_pkg::react_auto,
            protection_pkg::react_fast:  state_next = protection_pkg::st_wait;
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         state_reg <= protection_pkg::st_recharge;
      end else begin
         state_reg <= state_next;
      end
   end

   // Gate follows the next state, so it drops at the edge after the trip
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         o_gate_enable <= 1'b0;
      end else begin
         o_gate_enable <= (state_next == protection_pkg::st_prestart) ||
                          (state_next == protection_pkg::st_startup) ||
                          (state_next == protection_pkg::st_regulated);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         wait_cnt_reg <= '0;
      end else if (trip) begin
         wait_cnt_reg <= (react == protection_pkg::react_fast) ? `FAST_RESTART_MS : restart_ms;
      end else if (state_reg == protection_pkg::st_wait && ms_tick && wait_cnt_reg != '0) begin
         wait_cnt_reg <= wait_cnt_reg - 12'h001;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         dis_cnt_reg       <= '0;
         o_discharge_pulse <= 1'b0;
      end else if (state_reg == protection_pkg::st_wait && state_next == protection_pkg::st_discharge) begin
         dis_cnt_reg       <= 16'({6'h00, i_config.discharge_pulse_width} * US_CYC);
         o_discharge_pulse <= (i_config.discharge_pulse_width != '0);
      end else if (state_next == protection_pkg::st_discharge) begin
         dis_cnt_reg <= dis_cnt_reg - 16'h0001;
      end else begin
         dis_cnt_reg       <= '0;
         o_discharge_pulse <= 1'b0;
      end
   end

   // Startup cell runs as a hysteresis loop while latched, waiting, discharging or recharging, but not when stopped
   assign hv_hold = (state_reg == protection_pkg::st_latched) || (state_reg == protection_pkg::st_wait) ||
                    (state_reg == protection_pkg::st_discharge) || (state_reg == protection_pkg::st_recharge);

   always_ff @(posedge i_mclk) begin
      if (!i_resetn || !hv_hold) begin
         o_hv_startup_enable <= 1'b0;
      end else if (i_supply_below_lower) begin
         o_hv_startup_enable <= 1'b1;
      end else if (i_supply_above_upper) begin
         o_hv_startup_enable <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         o_hw_restart <= 1'b0;
      end else begin
         o_hw_restart <= (state_reg == protection_pkg::st_latched || state_reg == protection_pkg::st_stopped) &&
                         i_supply_below_off;
      end
   end

   // The code of the winning trip is kept until the next trip or a hardware restart
   always_ff @(posedge i_mclk) begin
      if (!i_resetn || o_hw_restart) begin
         o_status_code <= `CODE_NONE;
      end else if (trip) begin
         o_status_code <= code;
      end
   end

   sequence s_wait_expire;
      state_reg == protection_pkg::st_wait && wait_cnt_reg == '0;
   endsequence
   sequence s_pulse_start;
      ##1 state_reg == protection_pkg::st_discharge;
   endsequence

   a_gate_off_fast: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (trip && !gate_tick) |=> !o_gate_enable)
      else $error("gate not off after trip");
   a_gate_held_off: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (state_reg == protection_pkg::st_wait || state_reg == protection_pkg::st_latched) |-> !o_gate_enable)
      else $error("gate on during reaction");
   a_latch_holds: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (state_reg == protection_pkg::st_latched && !i_supply_below_off) |=> state_reg == protection_pkg::st_latched)
      else $error("latch left early");
   a_restart_delay: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (trip && state_next == protection_pkg::st_wait) |=>
      wait_cnt_reg == (($past(react) == protection_pkg::react_fast) ? `FAST_RESTART_MS : $past(restart_ms)))
      else $error("wrong restart delay");
   a_hv_charge: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (state_reg == protection_pkg::st_wait && i_supply_below_lower) ##1 state_reg == protection_pkg::st_wait
      |-> o_hv_startup_enable)
      else $error("startup cell not charging");
   a_stop_restart: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (state_reg == protection_pkg::st_stopped && i_supply_below_off) |=> o_hw_restart ##1 !o_hw_restart)
      else $error("no single hardware restart");
   a_single_pulse: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      $rose(o_discharge_pulse) |-> $past(state_reg, 2) == protection_pkg::st_wait)
      else $error("discharge pulse without wait expiry");
   a_pulse_follows: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      s_wait_expire |-> s_pulse_start)
      else $error("wait expiry without discharge");
   a_prestart_gate: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (state_reg == protection_pkg::st_recharge && !i_supply_below_lower) |=> o_gate_enable)
      else $error("prestart without gate");
   a_debug_stop: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (trip && i_config.debug_halt) |=> state_reg == protection_pkg::st_stopped && o_status_code != `CODE_NONE)
      else $error("debug halt not stopped");
   a_first_wins: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (state_reg == protection_pkg::st_wait && $stable(state_reg)) |-> $stable(o_status_code))
      else $error("status overwritten while waiting");
   a_oc_blank: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      oc_trip |-> $past(i_faults.overcurrent) && $past(i_faults.overcurrent, 2))
      else $error("overcurrent not blanked");
endmodule : protection_reaction_sequencer

// File: supply_model.sv
// Purpose: Supply rail and power stage model facing the sequencer
// Assumes: One level step per cycle, thresholds fixed here
// Notes:   Aux winding only holds the rail while the gate runs
`timescale 1ns/1ps
module supply_model (
   input  wire logic i_mclk,
   input  wire logic i_resetn,
   input  wire logic i_gate_enable,
   input  wire logic i_hv_startup_enable,
   input  wire logic i_drain,
   output logic      o_below_off,
   output logic      o_below_lower,
   output logic      o_above_upper,
   output logic      o_prestart_done,
   output logic      o_startup_done
);
   logic [7:0] level_reg;
   logic [5:0] run_reg;
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) level_reg <= 8'h96;
      else if (i_drain && level_reg != 8'h00) level_reg <= level_reg - 8'h01; // Mains removed
      else if (!i_drain && i_hv_startup_enable && level_reg != 8'hFF) level_reg <= level_reg + 8'h01;
      else if (!i_gate_enable && level_reg != 8'h00) level_reg <= level_reg - 8'h01;
   end
   always_ff @(posedge i_mclk) begin
      if (!i_resetn || !i_gate_enable) run_reg <= 6'h00;
      else if (run_reg != 6'h3F) run_reg <= run_reg + 6'h01;
   end
   assign o_below_off     = level_reg < 8'h3C;
   assign o_below_lower   = level_reg < 8'h64;
   assign o_above_upper   = level_reg > 8'hC8;
   assign o_prestart_done = run_reg >= 6'h04;
   assign o_startup_done  = run_reg >= 6'h08;
endmodule : supply_model

// File: testbench.sv
// Purpose: Self-checking bench for the protection reaction sequencer
// Assumes: Millisecond tick shortened to 20 cycles
// Notes:   Restart delays kept near the minimum to bound run time
`timescale 1ns/1ps
module testbench;
   logic                       i_mclk, i_resetn, drain, sync, boff, blow, bup, pre, stu, gate, dis, hv, hwr;
   logic [15:0]                code;
   logic [7:0]                 samp;
   logic                       smin;
   protection_pkg::faults_t    flt;
   protection_pkg::config_t    cfg;
   protection_pkg::seq_state_t st;
   int                         error_cnt = 0, checks = 0, n, k, e;
   logic [15:0]                codes [4] = '{16'h0400, 16'h2000, 16'h0800, 16'h0020};
   protection_reaction_sequencer #(.FIXED_HALF_PERIOD_CYC(5120), .MS_TICK_CYCLES(20)) DUT (
      .i_mclk(i_mclk), .i_resetn(i_resetn), .i_line_sync_valid(sync), .i_line_period(18'h01400),
      .i_faults(flt), .i_config(cfg), .i_supply_sample(samp), .i_supply_below_off(boff),
      .i_supply_below_lower(blow), .i_supply_above_upper(bup), .i_prestart_done(pre),
      .i_input_above_start_max(1'b0), .i_input_below_start_min(smin), .i_startup_done(stu),
      .o_gate_enable(gate), .o_discharge_pulse(dis), .o_hv_startup_enable(hv), .o_hw_restart(hwr),
      .o_status_code(code), .o_state(st));
   supply_model partner (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_gate_enable(gate), .i_hv_startup_enable(hv),
      .i_drain(drain), .o_below_off(boff), .o_below_lower(blow), .o_above_upper(bup),
      .o_prestart_done(pre), .o_startup_done(stu));
   task automatic wrap_up();
      if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Pass when a cycle count lies within two ms ticks of the expectation
   task automatic chk_near(input int got, input int exp);
      chk({15'h0000, got >= exp - 40 && got <= exp + 40}, 16'h0001);
   endtask : chk_near
   task automatic wait_st(input protection_pkg::seq_state_t s, input int lim);
      n = 0;
      while (st !== s) begin
         @(negedge i_mclk);
         n++;
         if (n > lim) begin
            error_cnt++;
            wrap_up();
         end
      end
   endtask : wait_st
   task automatic wait_hwr();
      for (n = 0; hwr !== 1'b1; n++) begin
         @(negedge i_mclk);
         if (n > 3000) begin
            error_cnt++;
            wrap_up();
         end
      end
   endtask : wait_hwr
   // Trip from regulated mode, return once the sequencer has reacted
   task automatic trip(input protection_pkg::faults_t f, input protection_pkg::seq_state_t s);
      wait_st(protection_pkg::st_regulated, 3000);
      flt = f;
      wait_st(s, 20);
      chk({15'h0000, gate}, 16'h0000);
      flt = '0;
   endtask : trip
   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end
   initial begin
      i_resetn = 1'b0; drain = 1'b0; flt = '0; cfg = '0;
      samp = 8'hA0;
      smin = 1'b0;
      void'($urandom(32'h99AF));
      sync = 1'($urandom % 2);
      e = 400 + $urandom % 200;
      cfg.restart_delay_ms = 12'(e);
      cfg.discharge_pulse_width = 10'h005;
      cfg.output_undervoltage_blanking = 10'h3E8;
      cfg.overcurrent_blanking = 8'h04;
      cfg.supply_ovp_threshold = 8'hF0;
      cfg.input_undervoltage_enable = 1'b1;
      cfg.output_overvoltage_reaction_select = 1'b1;
      repeat (4) @(negedge i_mclk);
      chk(code, 16'h0000);
      chk({12'h000, st}, {12'h000, protection_pkg::st_recharge});
      i_resetn = 1'b1;
      k = $urandom % 4;
      // Overcurrent goes alone: during its blanking any companion fault would trip first
      trip('{misc_fault: k != 0, overcurrent: k == 0, overtemp: k == 1, supply_uv: k == 2, default: 1'b0},
           protection_pkg::st_wait);
      chk(code, codes[k]);
      wait_st(protection_pkg::st_discharge, 20000);
      chk_near(n, e * 20);
      chk({14'h0000, dis, gate}, 16'h0002);
      wait_st(protection_pkg::st_recharge, 400);
      chk_near(n, 100);
      wait_st(protection_pkg::st_prestart, 500);
      chk({15'h0000, gate}, 16'h0001);
      trip('{fast_watchdog: 1'b1, default: 1'b0}, protection_pkg::st_wait);
      wait_st(protection_pkg::st_discharge, 20000);
      chk_near(n, 8000);
      chk({15'h0000, boff}, 16'h0000);
      wait_st(protection_pkg::st_regulated, 3000);
      samp = 8'hF1 + 8'($urandom % 8);
      wait_st(protection_pkg::st_wait, 400);
      chk(code, 16'h1000);
      samp = 8'hA0;
      wait_st(protection_pkg::st_discharge, 20000);
      chk_near(n, e * 20);
      smin = 1'b1;
      wait_st(protection_pkg::st_wait, 3000);
      chk(code, 16'h0040);
      smin = 1'b0;
      wait_st(protection_pkg::st_discharge, 20000);
      trip('{output_ov: 1'b1, default: 1'b0}, protection_pkg::st_latched);
      chk(code, 16'h0100);
      repeat (3000) @(negedge i_mclk);
      chk({12'h000, st}, {12'h000, protection_pkg::st_latched});
      drain = 1'b1;
      wait_hwr();
      chk({14'h0000, hv, hwr}, 16'h0003);
      drain = 1'b0;
      repeat (2) @(negedge i_mclk);
      chk(code, 16'h0000);
      cfg.debug_halt = 1'b1;
      trip('{input_uv: 1'b1, default: 1'b0}, protection_pkg::st_stopped);
      chk(code, 16'h0040);
      drain = 1'b1;
      wait_hwr();
      chk({14'h0000, hv, hwr}, 16'h0001);
      wrap_up();
   end
endmodule : testbench
